// file: shared/lds_map.vh
// Constants for the LED driver serial load and error block
`ifndef LDS_MAP_VH
`define LDS_MAP_VH

// ---------------------------------------------
// Shift chain geometry
// ---------------------------------------------
`define LDS_GS_BITS 192
`define LDS_DC_BITS 96
`define LDS_CHANNELS 16
`define LDS_CNT_W 8
`define LDS_GS_TOP 8'hBF
`define LDS_DC_TOP 8'h5F
`define LDS_TEF_OFS 8'h10

// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define LDS_OFF_CTRL 4'h0
`define LDS_OFF_STATUS 4'h4
`define LDS_OFF_LOD 4'h8
`define LDS_OFF_COUNT 4'hC

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define LDS_CTRL_CAPTURE 0
`define LDS_ST_OVERTEMP 0
`define LDS_ST_OPEN_LED 1
`define LDS_ST_MODE 2
`define LDS_ST_LATCH 3
`define LDS_ST_BLANK 4
`define LDS_ST_ERROR 5

// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define LDS_RST_GS 192'h0
`define LDS_RST_DC 96'h0
`define LDS_RST_RDATA 32'h0

`endif

// file: src/lds_serial_latch.v
// Serial load path, latches, status readout and error output of the LED driver
// Overview of operation
// - Shift serial_in on each shift_clock rising edge
// - Latch strobe copies shift register into registers
// - First bit received becomes word MSB
// - Chain length 96 or 192 by mode
// - Strobe high writes grayscale or correction register
// - Strobe low holds both registers unchanged
// - Shifting leaves grayscale values alone while strobe is low; with strobe high in grayscale mode they follow the shift register
// - Latched grayscale replaces old values at once
// - Serial_out carries bits leaving shift register
// - Status bits readable through serial_out
// - Error pull-down on open-LED or overtemperature
// - No error leaves pull-down released
// - Error is OR of both flags
// - Output disable masks open-LED contribution
// - Mode low grayscale, high dot correction
// - Correction mode 96 bits, grayscale 192
// - Disable forces channels off, clears counter
// - Strobe falling edge captures open-LED status
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`include "lds_map.vh"
`default_nettype none

module lds_serial_latch (
   input wire clk,
   input wire sys_rst,
   input wire shift_clock,
   input wire serial_in,
   input wire latch_strobe,
   input wire mode,
   input wire output_disable,
   input wire overtemp_detect,
   input wire [`LDS_CHANNELS-1:0] open_led_detect,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   output reg serial_out,
   output reg error_flag_output,
   output reg error_flag_oe_n,
   output reg [`LDS_GS_BITS-1:0] grayscale_register,
   output reg [`LDS_DC_BITS-1:0] dot_correction_register,
   output reg sink_channel_off,
   output reg gs_counter_clear
);

   // ---------------------------------------------
   // Bus states
   // ---------------------------------------------
   localparam ST_IDLE = 2'b01;
   localparam ST_DONE = 2'b10;

   // ---------------------------------------------
   // Top index of the active chain
   // ---------------------------------------------
   function [7:0] top_index;
      input dc_mode;
      begin
         if (dc_mode) begin
            top_index = `LDS_DC_TOP;
         end else begin
            top_index = `LDS_GS_TOP;
         end
      end
   endfunction

   // ---------------------------------------------
   // Input synchronisers
   // ---------------------------------------------
   reg sck_q1_reg;
   reg sck_q2_reg;
   reg sck_q3_reg;
   reg sin_q1_reg;
   reg sin_q2_reg;
   reg lat_q1_reg;
   reg lat_q2_reg;
   reg lat_q3_reg;
   reg mode_q1_reg;
   reg mode_q2_reg;
   reg blank_q1_reg;
   reg blank_q2_reg;
   reg tef_q1_reg;
   reg tef_q2_reg;
   reg [`LDS_CHANNELS-1:0] lod_q1_reg;
   reg [`LDS_CHANNELS-1:0] lod_q2_reg;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sck_q1_reg <= 1'b0;
         sck_q2_reg <= 1'b0;
         sck_q3_reg <= 1'b0;
         sin_q1_reg <= 1'b0;
         sin_q2_reg <= 1'b0;
         lat_q1_reg <= 1'b0;
         lat_q2_reg <= 1'b0;
         lat_q3_reg <= 1'b0;
         mode_q1_reg <= 1'b0;
         mode_q2_reg <= 1'b0;
         blank_q1_reg <= 1'b0;
         blank_q2_reg <= 1'b0;
         tef_q1_reg <= 1'b0;
         tef_q2_reg <= 1'b0;
         lod_q1_reg <= 16'h0000;
         lod_q2_reg <= 16'h0000;
      end else begin
         sck_q1_reg <= shift_clock;
         sck_q2_reg <= sck_q1_reg;
         sck_q3_reg <= sck_q2_reg;
         sin_q1_reg <= serial_in;
         sin_q2_reg <= sin_q1_reg;
         lat_q1_reg <= latch_strobe;
         lat_q2_reg <= lat_q1_reg;
         lat_q3_reg <= lat_q2_reg;
         mode_q1_reg <= mode;
         mode_q2_reg <= mode_q1_reg;
         blank_q1_reg <= output_disable;
         blank_q2_reg <= blank_q1_reg;
         tef_q1_reg <= overtemp_detect;
         tef_q2_reg <= tef_q1_reg;
         lod_q1_reg <= open_led_detect;
         lod_q2_reg <= lod_q1_reg;
      end
   end

   // ---------------------------------------------
   // Edge detection and flags
   // ---------------------------------------------
   wire shift_edge;
   wire latch_fall;
   wire overtemp_flag;
   wire open_led_flag;
   wire [7:0] top;

   assign shift_edge = sck_q2_reg & ~sck_q3_reg;
   assign latch_fall = lat_q3_reg & ~lat_q2_reg;
   assign overtemp_flag = tef_q2_reg;
   assign open_led_flag = (|lod_q2_reg) & ~blank_q2_reg;
   assign top = top_index(mode_q2_reg);

   // ---------------------------------------------
   // Bus state and registers
   // ---------------------------------------------
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg capture_req_reg;
   reg [`LDS_CHANNELS-1:0] lod_status_reg;
   reg [`LDS_CNT_W-1:0] shift_count_reg;
   wire bus_req;
   wire bus_done;
   wire ctrl_hit;

   assign bus_req = avs_read | avs_write;
   assign bus_done = state_reg == ST_DONE;
   assign ctrl_hit = avs_write & bus_done & (avs_address == `LDS_OFF_CTRL);

   always @* begin
      case (state_reg)
         ST_IDLE: begin
            if (bus_req) begin
               state_next = ST_DONE;
            end else begin
               state_next = ST_IDLE;
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------
   // Read data mux
   // ---------------------------------------------
   reg [31:0] rdata_next;

   always @* begin
      rdata_next = 32'h0000_0000;
      case (avs_address)
         `LDS_OFF_STATUS: begin
            rdata_next[`LDS_ST_OVERTEMP] = overtemp_flag;
            rdata_next[`LDS_ST_OPEN_LED] = open_led_flag;
            rdata_next[`LDS_ST_MODE] = mode_q2_reg;
            rdata_next[`LDS_ST_LATCH] = lat_q2_reg;
            rdata_next[`LDS_ST_BLANK] = blank_q2_reg;
            rdata_next[`LDS_ST_ERROR] = ~error_flag_oe_n;
         end
         `LDS_OFF_LOD: begin
            rdata_next[`LDS_CHANNELS-1:0] = lod_status_reg;
         end
         `LDS_OFF_COUNT: begin
            rdata_next[`LDS_CNT_W-1:0] = shift_count_reg;
         end
         default: begin
            rdata_next = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= `LDS_RST_RDATA;
         capture_req_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         avs_waitrequest <= ~(state_next == ST_DONE);
         if (avs_read & (state_next == ST_DONE)) begin
            avs_readdata <= rdata_next;
         end
         capture_req_reg <= ctrl_hit & avs_writedata[`LDS_CTRL_CAPTURE];
      end
   end

   // ---------------------------------------------
   // Input shift register and status load
   // ---------------------------------------------
   reg [`LDS_GS_BITS-1:0] shift_reg;
   reg [`LDS_GS_BITS-1:0] status_word;
   integer i;

   always @* begin
      status_word = shift_reg;
      for (i = 0; i < `LDS_CHANNELS; i = i + 1) begin
         status_word[top - i[7:0]] = lod_q2_reg[`LDS_CHANNELS-1-i];
      end
      status_word[top - `LDS_TEF_OFS] = overtemp_flag;
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= `LDS_RST_GS;
         lod_status_reg <= 16'h0000;
         shift_count_reg <= 8'h00;
      end else begin
         if (latch_fall | capture_req_reg) begin
            lod_status_reg <= lod_q2_reg;
            shift_reg <= status_word;
            shift_count_reg <= 8'h00;
         end else if (shift_edge) begin
            shift_reg <= {shift_reg[`LDS_GS_BITS-2:0], sin_q2_reg};
            shift_count_reg <= shift_count_reg + 8'h01;
         end
      end
   end

   // ---------------------------------------------
   // Serial output
   // ---------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         serial_out <= 1'b0;
      end else begin
         serial_out <= shift_reg[top];
      end
   end

   // ---------------------------------------------
   // Grayscale and correction latches
   // ---------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         grayscale_register <= `LDS_RST_GS;
         dot_correction_register <= `LDS_RST_DC;
      end else begin
         if (lat_q2_reg) begin
            if (mode_q2_reg) begin
               dot_correction_register <= shift_reg[`LDS_DC_BITS-1:0];
            end else begin
               grayscale_register <= shift_reg;
            end
         end
      end
   end

   // ---------------------------------------------
   // Error output and channel disable
   // ---------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         error_flag_output <= 1'b0;
         error_flag_oe_n <= 1'b1;
         sink_channel_off <= 1'b1;
         gs_counter_clear <= 1'b1;
      end else begin
         error_flag_output <= 1'b0;
         error_flag_oe_n <= ~(overtemp_flag | open_led_flag);
         sink_channel_off <= blank_q2_reg;
         gs_counter_clear <= blank_q2_reg;
      end
   end

endmodule

`default_nettype wire

// file: testbench/lds_serial_latch_properties.sv
// Checker of the LED driver serial load and error block
`include "lds_map.vh"
`default_nettype none
module lds_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic shift_clock,
   input wire logic latch_strobe,
   input wire logic mode,
   input wire logic output_disable,
   input wire logic overtemp_detect,
   input wire logic [`LDS_CHANNELS-1:0] open_led_detect,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic serial_out,
   input wire logic error_flag_output,
   input wire logic error_flag_oe_n,
   input wire logic [`LDS_GS_BITS-1:0] grayscale_register,
   input wire logic [`LDS_DC_BITS-1:0] dot_correction_register,
   input wire logic sink_channel_off,
   input wire logic gs_counter_clear
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_wait_pulse: assert property (!avs_waitrequest |-> $past(avs_read || avs_write) ##1 avs_waitrequest)
      else $error("waitrequest answer not a single cycle");
   a_temp_error: assert property (overtemp_detect [*5] |-> !error_flag_oe_n && !error_flag_output)
      else $error("overtemperature does not pull error low");
   a_led_error: assert property ((open_led_detect != 16'h0 && !output_disable) [*5] |-> !error_flag_oe_n)
      else $error("open LED does not pull error low");
   a_error_free: assert property (
      (!overtemp_detect && (output_disable || open_led_detect == 16'h0)) [*5] |-> error_flag_oe_n)
      else $error("error pull-down on without cause");
   a_blank_on: assert property (output_disable [*5] |-> sink_channel_off && gs_counter_clear)
      else $error("blank does not force channels off");
   a_blank_off: assert property (!output_disable [*5] |-> !sink_channel_off && !gs_counter_clear)
      else $error("channels held off without blank");
   a_latch_hold: assert property (!latch_strobe [*5] |->
      $stable(grayscale_register) && $stable(dot_correction_register))
      else $error("register changed with strobe low");
   a_gs_only: assert property ((latch_strobe && !mode) [*5] |-> $stable(dot_correction_register))
      else $error("correction register written in grayscale mode");
   a_dc_only: assert property ((latch_strobe && mode) [*5] |-> $stable(grayscale_register))
      else $error("grayscale register written in correction mode");
   a_serial_out_quiet: assert property (
      (!shift_clock && !latch_strobe && !avs_write && $stable(mode)) [*8] |-> $stable(serial_out))
      else $error("serial_out moved without shift or capture");
   c_gs_latch: cover property (latch_strobe && !mode);
   c_dc_latch: cover property (latch_strobe && mode);
   c_err: cover property ($fell(error_flag_oe_n));
endmodule
bind lds_serial_latch lds_chk u_lds_chk (.*);
`default_nettype wire

// file: testbench/lds_ctl_model.sv
// Controller model driving the serial chain of the LED driver
`default_nettype none
module lds_ctl_model (
   input wire logic clk,
   output logic shift_clock,
   output logic serial_in,
   output logic latch_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      shift_clock = 1'b0;
      serial_in = 1'b1;
      latch_strobe = 1'b0;
   end
   task automatic send(input logic [191:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk);
         serial_in <= w[i];
         repeat (3) @(posedge clk);
         shift_clock <= 1'b1;
         repeat (4) @(posedge clk);
         shift_clock <= 1'b0;
      end
      repeat (4) @(posedge clk);
      serial_in <= ~serial_in;
      repeat (2) @(posedge clk);
   endtask
   task automatic latch();
      repeat (4) @(posedge clk);
      latch_strobe <= 1'b1;
      repeat (8) @(posedge clk);
      latch_strobe <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// file: testbench/tb_led_driver_serial_latch_error.sv
// Testbench of the LED driver serial load and error block
`include "lds_map.vh"
`default_nettype none
module tb_led_driver_serial_latch_error;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, shift_clock, serial_in, latch_strobe, mode, output_disable, overtemp_detect;
   logic avs_read, avs_write, avs_waitrequest, serial_out, error_flag_output, error_flag_oe_n;
   logic sink_channel_off, gs_counter_clear;
   logic [15:0] open_led_detect;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [`LDS_GS_BITS-1:0] grayscale_register, pg;
   logic [`LDS_DC_BITS-1:0] dot_correction_register, pd;
   int failures, comparisons, cycles;
   lds_serial_latch u_lds_serial_latch (.*);
   lds_ctl_model u_lds_ctl_model (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("MISMATCH t=%0t timeout", $time);
         tally_and_finish;
      end
   end
   task automatic chk(input logic [191:0] g, input logic [191:0] e);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~wr;
      avs_write <= wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic t_reset;
      chk(avs_waitrequest, 1'b1);
      chk(error_flag_oe_n, 1'b1);
      chk(sink_channel_off, 1'b1);
      $display("reset test done");
   endtask
   task automatic t_gray;
      @(posedge clk);
      mode <= 1'b0;
      pg = {64'hC123456789ABCDEF, 64'hFEDCBA9876543210, 64'h8000000000000001};
      u_lds_ctl_model.send(pg, 192);
      chk(grayscale_register, '0);
      chk(serial_out, pg[191]);
      u_lds_ctl_model.latch();
      chk(grayscale_register, pg);
      chk(dot_correction_register, '0);
      $display("grayscale test done");
   endtask
   task automatic t_dot;
      @(posedge clk);
      mode <= 1'b1;
      pd = 96'hF0E1D2C3B4A5968778695A4B;
      u_lds_ctl_model.send(pd, 96);
      u_lds_ctl_model.latch();
      chk(dot_correction_register, pd);
      chk(grayscale_register, pg);
      $display("correction test done");
   endtask
   task automatic t_status;
      @(posedge clk);
      open_led_detect <= 16'hA5C3;
      overtemp_detect <= 1'b1;
      u_lds_ctl_model.latch();
      chk(serial_out, 1'b1);
      chk(error_flag_oe_n, 1'b0);
      u_lds_ctl_model.send('0, 1);
      chk(serial_out, 1'b0);
      u_lds_ctl_model.send('0, 15);
      chk(serial_out, 1'b1);
      bus(1'b0, 4'hC, 32'h0);
      chk(rd, 32'h10);
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, 32'hA5C3);
      $display("status test done");
   endtask
   task automatic t_error;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         overtemp_detect <= i[2];
         open_led_detect <= {15'h0, i[1]};
         output_disable <= i[0];
         repeat (6) @(posedge clk);
         chk(error_flag_oe_n, !(i[2] || (i[1] && !i[0])));
         chk(sink_channel_off, i[0]);
         chk(gs_counter_clear, i[0]);
      end
      chk(error_flag_output, 1'b0);
      $display("error test done");
   endtask
   task automatic t_bus;
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 4'h4, 32'hFFFFFFFF);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h35);
      bus(1'b1, 4'h0, 32'h1);
      repeat (4) @(posedge clk);
      chk(serial_out, 1'b0);
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h1);
      $display("bus test done");
   endtask
   initial begin
      sys_rst = 1'b1;
      mode = 1'b0;
      output_disable = 1'b0;
      overtemp_detect = 1'b0;
      open_led_detect = 16'h0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      failures = 0;
      comparisons = 0;
      cycles = 0;
      repeat (6) @(posedge clk);
      t_reset;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_gray;
      t_dot;
      t_status;
      t_error;
      t_bus;
      tally_and_finish;
   end
endmodule
`default_nettype wire
